//--- logic/mra_arbiter.sv
`timescale 1ns/1ps
module mra_arbiter import mra_pkg::*; #(
	// Cycles per second; shorten for simulation
	parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Request pins, asynchronous
	input wire logic [3:0] userReqIn,
	input wire logic [1:0] fkeyReqIn,
	input wire logic binReqIn,
	input wire logic [3:0] binMsgIn,
	input wire logic [3:0] outReqIn,
	input wire logic cancelIn,
	// Source assignment
	input wire logic [10:0] srcEnable,
	input wire logic [43:0] srcMsgMap,
	// Serial port commands, core clock pulses
	input wire logic serReq,
	input wire logic [3:0] serMsg,
	input wire logic serCancel,
	// Message settings write port
	input wire logic cfgWrite,
	input wire logic [3:0] cfgAddr,
	input wire logic [3:0] cfgPrio,
	input wire logic [1:0] cfgType,
	input wire logic cfgFlash,
	input wire logic cfgAlt,
	input wire logic cfgHeld,
	input wire logic [1:0] cfgMode,
	input wire logic [9:0] cfgTime,
	input wire logic [2:0] cfgLastBlock,
	// Display driver
	input wire logic scrollEnd,
	input wire logic [7:0] glyphCode,
	// Display control
	output logic msgShown,
	output logic [3:0] msgIndex,
	output logic msgVisible,
	output logic showIndication,
	output logic [2:0] blockIndex,
	output logic glyphStandard
);

	// All arbiter state
	typedef struct packed {
		logic [10:0] pinMeta;
		logic [10:0] pinSync;
		logic [3:0] binMeta;
		logic [3:0] binSync;
		logic cancelMeta;
		logic cancelSync;
		logic cancelPrev;
		logic [10:0] srcPrev;
		logic [SEC_W-1:0] secCnt;
		logic showing;
		logic [3:0] curMsg;
		logic [3:0] curSrc;
		logic fromSerial;
		logic [9:0] elapsed;
		logic pairPhase;
		logic [2:0] block;
		logic visible;
		logic indic;
		logic glyphOk;
	} mra_state_s;

	mra_state_s r; // Current state
	mra_state_s n; // Next state
	mra_cfg_s cfg; // Settings of the shown message
	logic [29:0] prioVec; // Priority code per message
	logic [9:0] heldVec; // Held flag per message
	logic [3:0] srcMsg [SRC_COUNT]; // Message each source asks for
	logic [10:0] act; // Sources active now
	logic [10:0] rise; // Sources freshly activated
	logic [10:0] heldAct; // Active sources of held messages
	logic [4:0] risePick; // Highest ranked fresh source
	logic [4:0] heldPick; // Highest ranked held source
	logic tick; // One-second strobe
	logic cancelEdge; // Cancel input activation
	logic riseOk; // Fresh request may replace the display
	logic serOk; // Serial request may replace the display
	logic take; // A new message is shown next
	logic endNow; // Shown message ends this cycle
	logic timeUp; // Programmed time has run out
	logic boundary; // Two-second block boundary
	logic anyIdle; // An assigned source is inactive

	mra_cfg_mem u_cfg (
		.core_clk(core_clk),
		.rst(rst),
		.cfgWrite(cfgWrite),
		.cfgAddr(cfgAddr),
		.cfgPrio(cfgPrio),
		.cfgType(cfgType),
		.cfgFlash(cfgFlash),
		.cfgAlt(cfgAlt),
		.cfgHeld(cfgHeld),
		.cfgMode(cfgMode),
		.cfgTime(cfgTime),
		.cfgLastBlock(cfgLastBlock),
		.rdAddr(n.curMsg),
		.rdData(cfg),
		.prioVec(prioVec),
		.heldVec(heldVec)
	);

	// Equal or higher priority may replace; smaller code wins
	function automatic logic beats(input logic [3:0] m, input logic shown,
		input logic [3:0] cur, input logic [29:0] pv);
		return !shown || (pv[m*3 +: 3] <= pv[cur*3 +: 3]);
	endfunction

	// Next-state logic: sync, timebase, arbitration, display timers
	always_comb begin
		n = r;
		// Pins pass two flops before use
		n.pinMeta = {outReqIn, binReqIn, fkeyReqIn, userReqIn};
		n.pinSync = r.pinMeta;
		n.binMeta = binMsgIn;
		n.binSync = r.binMeta;
		n.cancelMeta = cancelIn;
		n.cancelSync = r.cancelMeta;
		n.cancelPrev = r.cancelSync;
		cancelEdge = r.cancelSync && !r.cancelPrev;
		// Free-running shared second counter
		tick = (r.secCnt == SEC_W'(SEC_CYCLES - 1));
		n.secCnt = tick ? '0 : SEC_W'(r.secCnt + 1'b1);
		boundary = tick && r.pairPhase;
		// Source activity, ordered by rank
		anyIdle = 1'b0;
		for (int i = 0; i < SRC_COUNT; i++) begin
			srcMsg[i] = (i == SRC_BIN) ? r.binSync : srcMsgMap[i*4 +: 4];
			act[i] = r.pinSync[i] && srcEnable[i] && srcMsg[i] <= MSG_LAST;
			heldAct[i] = act[i] && heldVec[srcMsg[i]];
			if (srcEnable[i] && srcMsg[i] == r.curMsg && !act[i]) begin
				anyIdle = 1'b1;
			end
		end
		n.srcPrev = act;
		// Fresh edges request, and held sources when idle; a dropped one-shot needs a new one
		rise = act & ~r.srcPrev;
		risePick = mraFirstSet(rise);
		heldPick = mraFirstSet(heldAct);
		riseOk = risePick[4] &&
			beats(srcMsg[risePick[3:0]], r.showing, r.curMsg, prioVec);
		serOk = serReq && serMsg <= MSG_LAST &&
			beats(serMsg, r.showing, r.curMsg, prioVec);
		// Time out once the programmed seconds have passed
		timeUp = (r.elapsed >= cfg.timeSec);
		// Cancellation of the shown message
		endNow = 1'b0;
		if (r.showing) begin
			if (cancelEdge || serCancel) endNow = 1'b1;
			unique case (cfg.mode)
				MODE_LATCHED: ; // Never ends by itself
				MODE_TIMED: begin
					if (!mraIsBlock(cfg.msgType)) begin
						if (timeUp && scrollEnd) endNow = 1'b1;
					end else if (timeUp &&
						(cfg.msgType == TYPE_BLOCK1 ||
						r.elapsed >= BLOCK_SEC) &&
						(cfg.lastBlock == 3'h0 ||
						(boundary && r.block == cfg.lastBlock))) begin
						endNow = 1'b1;
					end
				end
				MODE_UNTIL_END: begin
					if (r.fromSerial) begin
						if (anyIdle) endNow = 1'b1;
					end else if (!act[r.curSrc]) begin
						endNow = 1'b1;
					end
				end
				MODE_SPARE: ; // Treated as latched
			endcase
		end
		// A displaced one-shot is simply never re-raised
		take = riseOk || serOk || (!r.showing && heldPick[4]);
		if (take) begin
			n.showing = 1'b1;
			if (riseOk) begin
				n.curSrc = risePick[3:0];
				n.curMsg = srcMsg[risePick[3:0]];
				n.fromSerial = 1'b0;
			end else if (serOk) begin
				n.curSrc = 4'h0;
				n.curMsg = serMsg;
				n.fromSerial = 1'b1;
			end else begin
				n.curSrc = heldPick[3:0];
				n.curMsg = srcMsg[heldPick[3:0]];
				n.fromSerial = 1'b0;
			end
			n.elapsed = '0;
			n.pairPhase = 1'b0;
			n.block = 3'h0;
			n.visible = 1'b1;
			n.indic = 1'b0;
		end else if (endNow) begin
			n.showing = 1'b0;
			n.visible = 1'b0;
			n.indic = 1'b0;
			n.block = 3'h0;
		end else if (r.showing && tick) begin
			// Seconds on display, saturating
			if (r.elapsed != ELAPSED_MAX) n.elapsed = r.elapsed + 10'h001;
			n.pairPhase = !r.pairPhase;
			// Flash toggles each second, block types only
			n.visible = (cfg.flashEnable && mraIsBlock(cfg.msgType)) ?
				!r.visible : 1'b1;
			if (boundary && mraIsBlock(cfg.msgType)) begin
				// Two seconds message, two seconds indication
				if (cfg.alternateWithIndication) n.indic = !r.indic;
				// Next block only after a message phase
				if (!r.indic) begin
					n.block = (r.block >= cfg.lastBlock) ? 3'h0 :
						r.block + 3'h1;
				end
			end
		end
		// Character code check for the text path
		n.glyphOk = glyphCode >= CHAR_FIRST && glyphCode <= CHAR_LAST;
	end

	// State register; all timers clear at reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign msgShown = r.showing;
	assign msgIndex = r.curMsg;
	assign msgVisible = r.visible;
	assign showIndication = r.indic;
	assign blockIndex = r.block;
	assign glyphStandard = r.glyphOk;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// A winning fresh request
	sequence s_riseWins;
		riseOk;
	endsequence

	// Idle with a held source waiting
	sequence s_idleHeld;
		!r.showing && !riseOk && !serOk && heldPick[4];
	endsequence

	a_prio_replace: assert property (s_riseWins |=>
		msgShown && msgIndex == $past(srcMsg[risePick[3:0]]))
		else $error("winning request not shown");
	a_held_pickup: assert property (s_idleHeld |=>
		msgShown && r.curSrc == $past(heldPick[3:0]))
		else $error("held source not picked up");
	a_flash_scroll: assert property (msgShown &&
		!mraIsBlock(cfg.msgType) && !$past(take) |-> msgVisible)
		else $error("scrolling message flashed");
	a_flash_toggle: assert property (msgShown && tick && !take && !endNow &&
		cfg.flashEnable && mraIsBlock(cfg.msgType) |=>
		msgVisible != $past(msgVisible))
		else $error("flash did not toggle");
	a_latched_hold: assert property (msgShown && cfg.mode == MODE_LATCHED &&
		!cancelEdge && !serCancel |=> msgShown)
		else $error("latched message ended by itself");
	a_cancel_end: assert property ((cancelEdge || serCancel) &&
		msgShown && !take |=> !msgShown)
		else $error("cancel did not end message");
	a_source_end: assert property (msgShown && !take &&
		cfg.mode == MODE_UNTIL_END && !r.fromSerial && !act[r.curSrc] |=>
		!msgShown)
		else $error("until-end message outlived source");
	a_block2_min: assert property (msgShown && cfg.mode == MODE_TIMED &&
		cfg.msgType == TYPE_BLOCK2 && r.elapsed < BLOCK_SEC &&
		!cancelEdge && !serCancel |=> msgShown)
		else $error("two-line block ended too early");
	a_timed_end: assert property (msgShown && !take &&
		cfg.mode == MODE_TIMED && cfg.msgType == TYPE_BLOCK1 &&
		cfg.lastBlock == 3'h0 && timeUp |=> !msgShown)
		else $error("timed message did not expire");

endmodule // mra_arbiter

//--- logic/mra_pkg.sv
package mra_pkg;

	// Sizes of the message store and the request sources
	localparam int MSG_COUNT = 10;
	localparam int SRC_COUNT = 11;
	localparam int SRC_BIN = 6;
	localparam logic [3:0] MSG_LAST = 4'h9;

	// Timebase: one-second tick derived from the core clock
	localparam int CLK_HZ = 20_000_000;
	localparam int SEC_PERIOD_MS = 1000;
	localparam int SEC_CYCLES_DEF = (CLK_HZ / 1000) * SEC_PERIOD_MS;
	localparam int SEC_W = 25;

	// Display timing in seconds
	localparam logic [9:0] BLOCK_SEC = 10'h002;
	localparam logic [9:0] ELAPSED_MAX = 10'h3ff;

	// Programmable ranges and defaults
	localparam logic [3:0] PRIO_MIN = 4'h1;
	localparam logic [3:0] PRIO_MAX = 4'h8;
	localparam logic [9:0] TIME_MIN = 10'h001;
	localparam logic [9:0] TIME_MAX = 10'h257;
	localparam logic [9:0] TIMED_DEFAULT_SEC = 10'h005;

	// Standard printable character range
	localparam logic [7:0] CHAR_FIRST = 8'h20;
	localparam logic [7:0] CHAR_LAST = 8'h7e;

	// Message layout on the display
	typedef enum logic [1:0] {
		TYPE_BLOCK1,
		TYPE_BLOCK2,
		TYPE_SCROLL1,
		TYPE_SCROLL2
	} mra_type_e;

	// How a shown message ends by itself
	typedef enum logic [1:0] {
		MODE_LATCHED,
		MODE_TIMED,
		MODE_UNTIL_END,
		MODE_SPARE
	} mra_mode_e;

	// One stored message setting; prio holds level minus one
	typedef struct packed {
		logic [2:0] prio;
		mra_type_e msgType;
		logic flashEnable;
		logic alternateWithIndication;
		logic heldRequest;
		mra_mode_e mode;
		logic [9:0] timeSec;
		logic [2:0] lastBlock;
	} mra_cfg_s;

	// Lowest set bit wins; bit 0 is the highest ranked source
	function automatic logic [4:0] mraFirstSet(input logic [10:0] v);
		logic [4:0] res;
		res = 5'h00;
		for (int i = SRC_COUNT - 1; i >= 0; i--) begin
			if (v[i]) begin
				res = {1'b1, 4'(i)};
			end
		end
		return res;
	endfunction

	// Block messages are the only ones that flash or alternate
	function automatic logic mraIsBlock(input mra_type_e t);
		return (t == TYPE_BLOCK1) || (t == TYPE_BLOCK2);
	endfunction

endpackage

//--- logic/mra_cfg_mem.sv
`timescale 1ns/1ps
module mra_cfg_mem import mra_pkg::*; (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Write port
	input wire logic cfgWrite,
	input wire logic [3:0] cfgAddr,
	input wire logic [3:0] cfgPrio,
	input wire logic [1:0] cfgType,
	input wire logic cfgFlash,
	input wire logic cfgAlt,
	input wire logic cfgHeld,
	input wire logic [1:0] cfgMode,
	input wire logic [9:0] cfgTime,
	input wire logic [2:0] cfgLastBlock,
	// Read port, data registered
	input wire logic [3:0] rdAddr,
	output mra_cfg_s rdData,
	// Registered per-message views for arbitration
	output logic [29:0] prioVec,
	output logic [9:0] heldVec
);

	// All state of the store
	typedef struct packed {
		mra_cfg_s [MSG_COUNT-1:0] mem;
		mra_cfg_s rd;
		logic [29:0] prio;
		logic [9:0] held;
	} mra_mem_s;

	mra_mem_s r; // Current state
	mra_mem_s n; // Next state
	mra_cfg_s wr; // Entry being written

	// Clamp and store writes, refresh the registered views
	always_comb begin
		n = r;
		wr = r.mem[cfgAddr];
		// Level 1 to 8 kept as 0 to 7
		if (cfgPrio < PRIO_MIN) wr.prio = 3'h0;
		else if (cfgPrio > PRIO_MAX) wr.prio = 3'h7;
		else wr.prio = 3'(cfgPrio - PRIO_MIN);
		wr.msgType = mra_type_e'(cfgType);
		wr.flashEnable = cfgFlash;
		wr.alternateWithIndication = cfgAlt;
		wr.heldRequest = cfgHeld;
		wr.mode = mra_mode_e'(cfgMode);
		wr.lastBlock = cfgLastBlock;
		// Display time held within 1 to 599 s
		if (cfgTime < TIME_MIN) wr.timeSec = TIME_MIN;
		else if (cfgTime > TIME_MAX) wr.timeSec = TIME_MAX;
		else wr.timeSec = cfgTime;
		// Entering timed mode loads the default time
		if (wr.mode == MODE_TIMED && r.mem[cfgAddr].mode != MODE_TIMED) begin
			wr.timeSec = TIMED_DEFAULT_SEC;
		end
		// Addresses past the last message are ignored
		if (cfgWrite && cfgAddr <= MSG_LAST) begin
			n.mem[cfgAddr] = wr;
		end
		// Out-of-range reads return the first entry
		n.rd = (rdAddr <= MSG_LAST) ? n.mem[rdAddr] : n.mem[0];
		for (int i = 0; i < MSG_COUNT; i++) begin
			n.prio[i*3 +: 3] = n.mem[i].prio;
			n.held[i] = n.mem[i].heldRequest;
		end
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign rdData = r.rd;
	assign prioVec = r.prio;
	assign heldVec = r.held;

endmodule // mra_cfg_mem

//--- testbench/mra_src_model.sv
`timescale 1ns/1ps
module mra_src_model (
	// Request pins toward the arbiter
	output logic [3:0] userReqIn,
	output logic [1:0] fkeyReqIn,
	output logic binReqIn,
	output logic [3:0] binMsgIn,
	output logic [3:0] outReqIn,
	// Cancel user input
	output logic cancelIn
);
	// Source levels in rank order, bit 0 ranks highest
	logic [10:0] srcLevel = 11'h000;
	// Cancel input level
	logic cancelLevel = 1'b0;

	// Pins follow the held levels; sources are plain levels
	assign userReqIn = srcLevel[3:0];
	assign fkeyReqIn = srcLevel[5:4];
	assign binReqIn = srcLevel[6];
	assign outReqIn = srcLevel[10:7];
	assign cancelIn = cancelLevel;
	// Binary inputs always name message six
	assign binMsgIn = 4'h6;

	// Raise or drop one source, called just after a clock edge
	task automatic setSrc(input int idx, input logic lvl);
		srcLevel[idx] = lvl;
	endtask

	// Raise or drop the cancel input
	task automatic setCancel(input logic lvl);
		cancelLevel = lvl;
	endtask
endmodule // mra_src_model

//--- testbench/message_request_arbiter_tb.sv
`timescale 1ns/1ps
module message_request_arbiter_tb import mra_pkg::*;;
	// Compare and count; case equality so unknowns never match
	`define CHK(nm, e, g) begin \
		total_checks++; \
		if ((g) !== (e)) begin \
			n_fail++; \
			$display("wrong value %s expected %0h seen %0h", nm, e, g); \
		end \
	end

	// Clock, reset and bench counters
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	int n_fail = 0;
	int total_checks = 0;
	int seed = 32'h3779;
	// Pins from the source model
	logic [3:0] userReqIn, binMsgIn, outReqIn;
	logic [1:0] fkeyReqIn;
	logic binReqIn, cancelIn;
	// Bench-driven inputs
	logic [10:0] srcEnable = 11'h7ff;
	logic [43:0] srcMsgMap;
	logic serReq = 1'b0;
	logic serCancel = 1'b0;
	logic [3:0] serMsg = 4'h0;
	logic cfgWrite = 1'b0;
	logic [3:0] cfgAddr = 4'h0;
	logic [3:0] cfgPrio = 4'h1;
	logic [1:0] cfgType = 2'h0;
	logic cfgFlash = 1'b0;
	logic cfgHeld = 1'b0;
	logic [1:0] cfgMode = 2'h0;
	logic [9:0] cfgTime = 10'h001;
	logic cfgAlt = 1'b0;
	logic [2:0] cfgLastBlock = 3'h0;
	// Scroll end strobe from the display side
	logic scrollEnd = 1'b0;
	// Cycle counter for the timing checks
	int k;
	logic [7:0] glyphCode = 8'h00;
	// Display outputs
	logic msgShown, msgVisible, showIndication, glyphStandard;
	logic [3:0] msgIndex;
	logic [2:0] blockIndex;
	// Scratch for the flash checks
	logic seen;
	logic lastVis;
	logic [7:0] corner [4] = '{8'h1f, 8'h20, 8'h7e, 8'h7f};

	// Twenty cycles a second keeps timed cases short
	always #25 core_clk = ~core_clk;

	// Far-side request sources
	mra_src_model src (.userReqIn(userReqIn), .fkeyReqIn(fkeyReqIn),
		.binReqIn(binReqIn), .binMsgIn(binMsgIn), .outReqIn(outReqIn),
		.cancelIn(cancelIn));

	mra_arbiter #(.SEC_CYCLES(20)) dut (.core_clk(core_clk), .rst(rst),
		.userReqIn(userReqIn), .fkeyReqIn(fkeyReqIn), .binReqIn(binReqIn),
		.binMsgIn(binMsgIn), .outReqIn(outReqIn), .cancelIn(cancelIn),
		.srcEnable(srcEnable), .srcMsgMap(srcMsgMap), .serReq(serReq),
		.serMsg(serMsg), .serCancel(serCancel), .cfgWrite(cfgWrite),
		.cfgAddr(cfgAddr), .cfgPrio(cfgPrio), .cfgType(cfgType),
		.cfgFlash(cfgFlash), .cfgAlt(cfgAlt), .cfgHeld(cfgHeld),
		.cfgMode(cfgMode), .cfgTime(cfgTime),
		.cfgLastBlock(cfgLastBlock),
		.scrollEnd(scrollEnd), .glyphCode(glyphCode), .msgShown(msgShown),
		.msgIndex(msgIndex), .msgVisible(msgVisible),
		.showIndication(showIndication), .blockIndex(blockIndex),
		.glyphStandard(glyphStandard));

	// Expected class of a character code
	function automatic logic isStd(input logic [7:0] c);
		return (c >= 8'h20) && (c <= 8'h7e);
	endfunction

	// Step n edges, then settle off the edge
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask

	// One whole settings entry; time is random to prove the default
	task automatic cfg(input logic [3:0] a, input logic [3:0] p,
		input logic [1:0] t, input logic [1:0] m, input logic h,
		input logic f);
		cfgAddr = a;
		cfgPrio = p;
		cfgType = t;
		cfgMode = m;
		cfgHeld = h;
		cfgFlash = f;
		cfgTime = 10'($random(seed));
		// Strobe stays high between back-to-back writes
		cfgWrite = 1'b1;
		tk(1);
	endtask

	// Serial cancel pulse
	task automatic serCut();
		serCancel = 1'b1;
		tk(1);
		serCancel = 1'b0;
	endtask

	// Verdict and end of run
	task automatic summarize();
		if (n_fail == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Watchdog sized well past the few hundred cycles expected
	initial begin
		#(4000 * 50);
		n_fail++;
		summarize();
	end

	// Main sequence
	initial begin
		// Source i asks for message i, the last output for nine
		for (int i = 0; i < 11; i++) begin
			srcMsgMap[4*i+:4] = (i > 9) ? 4'h9 : 4'(i);
		end
		tk(10);
		rst = 1'b0;
		tk(3);
		`CHK("shown", 1'b0, msgShown)
		// Random codes with the range edges first
		for (int i = 0; i < 24; i++) begin
			glyphCode = (i < 4) ? corner[i] : 8'($random(seed));
			tk(1);
			`CHK("glyph", isStd(glyphCode), glyphStandard)
		end
		// Default entries, then the special ones
		for (int i = 0; i < 10; i++) begin
			cfg(4'(i), 4'h4, 2'h0, 2'h0, 1'b0, 1'b0);
		end
		cfg(4'h1, 4'h4, 2'h0, 2'h2, 1'b0, 1'b0);
		cfg(4'h2, 4'h1, 2'h0, 2'h0, 1'b0, 1'b1);
		cfg(4'h3, 4'h4, 2'h0, 2'h1, 1'b0, 1'b0);
		cfg(4'h4, 4'h4, 2'h0, 2'h0, 1'b1, 1'b0);
		cfg(4'h5, 4'h6, 2'h2, 2'h1, 1'b0, 1'b0);
		cfg(4'h8, 4'h4, 2'h0, 2'h0, 1'b1, 1'b0);
		cfg(4'h9, 4'h1, 2'h2, 2'h0, 1'b0, 1'b1);
		// Two-line, two-block message alternating with the indication
		cfgAlt = 1'b1;
		cfgLastBlock = 3'h1;
		cfg(4'h6, 4'h1, 2'h1, 2'h0, 1'b0, 1'b0);
		cfgAlt = 1'b0;
		cfgLastBlock = 3'h0;
		cfgWrite = 1'b0;
		// Same-cycle requests: the higher ranked source wins
		src.setSrc(7, 1'b1);
		src.setSrc(0, 1'b1);
		tk(5);
		`CHK("index", 4'h0, msgIndex)
		tk(50);
		`CHK("latched", 1'b1, msgShown)
		`CHK("steady", 1'b1, msgVisible)
		serCut();
		`CHK("cut", 1'b0, msgShown)
		tk(5);
		`CHK("lost", 1'b0, msgShown)
		src.setSrc(7, 1'b0);
		tk(3);
		src.setSrc(7, 1'b1);
		tk(5);
		`CHK("index", 4'h7, msgIndex)
		// Lower level is lost, level one replaces
		src.setSrc(5, 1'b1);
		tk(5);
		`CHK("index", 4'h7, msgIndex)
		src.setSrc(2, 1'b1);
		tk(5);
		`CHK("index", 4'h2, msgIndex)
		seen = 1'b0;
		lastVis = msgVisible;
		repeat (22) begin
			tk(1);
			seen = seen | (msgVisible !== lastVis);
		end
		`CHK("flash", 1'b1, seen)
		src.setCancel(1'b1);
		tk(5);
		`CHK("cancel", 1'b0, msgShown)
		src.setCancel(1'b0);
		tk(5);
		`CHK("dropped", 1'b0, msgShown)
		// Scrolling type ignores flash
		src.setSrc(9, 1'b1);
		tk(5);
		`CHK("index", 4'h9, msgIndex)
		seen = 1'b0;
		repeat (22) begin
			tk(1);
			seen = seen | (msgVisible !== 1'b1);
		end
		`CHK("noflash", 1'b0, seen)
		serCut();
		for (int i = 0; i < 10; i++) begin
			src.setSrc(i, 1'b0);
		end
		// Held sources come back, highest ranked first
		src.setSrc(8, 1'b1);
		tk(5);
		`CHK("index", 4'h8, msgIndex)
		src.setSrc(4, 1'b1);
		tk(5);
		`CHK("index", 4'h4, msgIndex)
		serCut();
		tk(3);
		`CHK("pick", 4'h4, msgIndex)
		`CHK("shown", 1'b1, msgShown)
		// Let the dropped pin pass the synchroniser before cancelling
		src.setSrc(4, 1'b0);
		tk(3);
		serCut();
		tk(3);
		`CHK("back", 4'h8, msgIndex)
		`CHK("shown", 1'b1, msgShown)
		src.setSrc(8, 1'b0);
		tk(3);
		serCut();
		// Until-end by pin, then by serial with the pin low
		src.setSrc(1, 1'b1);
		tk(5);
		`CHK("index", 4'h1, msgIndex)
		src.setSrc(1, 1'b0);
		tk(5);
		`CHK("srcend", 1'b0, msgShown)
		serMsg = 4'h1;
		serReq = 1'b1;
		tk(1);
		serReq = 1'b0;
		tk(3);
		`CHK("serend", 1'b0, msgShown)
		// Timed entry was first latched, then written timed, so five seconds
		src.setSrc(3, 1'b1);
		tk(75);
		`CHK("timed", 1'b1, msgShown)
		tk(40);
		`CHK("expired", 1'b0, msgShown)
		src.setSrc(3, 1'b0);
		tk(2);
		// Alternation: indication stands two seconds, block moves on
		src.setSrc(6, 1'b1);
		tk(5);
		`CHK("index", 4'h6, msgIndex)
		k = 0;
		while (showIndication !== 1'b1 && k < 100) begin
			tk(1);
			k++;
		end
		`CHK("block", 3'h1, blockIndex)
		k = 0;
		while (showIndication === 1'b1 && k < 60) begin
			tk(1);
			k++;
		end
		`CHK("indication", 40, k)
		// Timed scrolling text waits for the end of its scroll
		serCut();
		src.setSrc(5, 1'b1);
		tk(5);
		`CHK("index", 4'h5, msgIndex)
		scrollEnd = 1'b1;
		tk(1);
		scrollEnd = 1'b0;
		tk(120);
		`CHK("scroll", 1'b1, msgShown)
		scrollEnd = 1'b1;
		tk(1);
		scrollEnd = 1'b0;
		`CHK("scrolled", 1'b0, msgShown)
		summarize();
	end
endmodule // message_request_arbiter_tb
